/* pkg/sdec_pkg.sv */
package sdec_pkg;
  // ----------------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int MOD_DIV          = 6;
  localparam int DEC_RATIO        = 64;
  localparam int SYS_PER_CONV     = MOD_DIV * DEC_RATIO;
  localparam int FILT_ORDER       = 5;
  localparam int FIRST_VALID      = 6;
  localparam int SYNC_VALID       = 4;
  localparam int RESULT_READY_N_MAX_NS      = 60;
  localparam int RESULT_READY_N_LOW_CYC     = (RESULT_READY_N_MAX_NS / CLK_PERIOD_NS) - 1;
  localparam int WRITE_CYC        = 1;
  // ----------------------------------------------------------------------
  // Result format
  // ----------------------------------------------------------------------
  localparam int RES_W            = 20;
  localparam int ACC_W            = 32;
  localparam int SCALE_SHIFT      = 11;
  localparam logic [19:0] RES_RESET = 20'h00000;
  localparam logic [19:0] POS_FULL  = 20'h7ffff;
  localparam logic [19:0] NEG_FULL  = 20'h80000;
  localparam logic [2:0]  MODCNT_W3 = 3'h5;

  typedef enum logic [2:0] {
    SDEC_RUN  = 3'b001,
    SDEC_HOLD = 3'b010,
    SDEC_ARM  = 3'b100
  } sdec_state_t;
endpackage

/* hdl/sdec_sinc5.sv */
`timescale 1ns/1ns
// Sinc^5 decimator: five integrators at the modulator rate, five combs at
// the output rate. Wrap-around arithmetic is exact as long as ACC_W holds
// the full gain of 64^5 (31 bits plus sign).
module sdec_sinc5 #(
  parameter int ACC_W = 32,
  parameter int ORDER = 5
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Modulator side
  input  wire logic             i_bit_en,
  input  wire logic             i_bit,
  // Decimation strobe
  input  wire logic             i_dec_en,
  // Result
  output logic                  o_valid,
  output logic signed [ACC_W-1:0] o_data
);
  logic signed [ACC_W-1:0] integ [ORDER+1];
  logic signed [ACC_W-1:0] comb_in [ORDER+1];
  logic signed [ACC_W-1:0] dly [ORDER];

  // Bitstream maps to +1 / -1.
  assign integ[0] = i_bit ? ACC_W'(1) : -ACC_W'(1);

  genvar k;
  generate
    for (k = 0; k < ORDER; k++) begin : g_stage
      logic signed [ACC_W-1:0] acc;
      // Integrators run on every modulator tick; sync never clears them.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          acc <= '0;
        end else if (i_bit_en) begin
          acc <= acc + integ[k];
        end
      end
      assign integ[k+1] = acc;
      // Comb differentiates against the value from one output period ago.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          dly[k] <= '0;
        end else if (i_dec_en) begin
          dly[k] <= comb_in[k];
        end
      end
      assign comb_in[k+1] = comb_in[k] - dly[k];
    end
  endgenerate
  assign comb_in[0] = integ[ORDER];

  // Registered result, one cycle after the decimation strobe.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data  <= '0;
    end else begin
      o_valid <= i_dec_en;
      if (i_dec_en) begin
        o_data <= comb_in[ORDER];
      end
    end
  end
endmodule

/* hdl/sdec_core.sv */
`timescale 1ns/1ns
// Function
// - Modulator tick is the system clock divided by six.
// - Filter is five cascaded length-64 moving averages, normalised by 64.
// - One result every 64 modulator ticks, that is 384 system clocks.
// - Step fully settles after five conversions, six if unaligned.
// - Linear phase; group delay is two and a half conversions.
// - Response is down 3 dB at 0.204 times the output rate.
// - Nulls at the output rate and all its integer multiples.
// - Each conversion loads the result register and pulls ready low.
// - After power-up the first pulse is invalid; the sixth is first valid.
// - Sync low clears the modulator count and holds it halted.
// - Rising edge of sync releases the modulator, counting aligned.
// - Sync does not clear filter state or the result register.
// - Sync after input change: the fifth conversion after release gives valid data.
// - A conversion interrupted by sync runs longer than normal.
// - Result register write completes within six system clocks.
// - Chip select falling after ready low returns ready high within six clocks.
// - Result is a 20-bit two's complement word, MSB first.
module sdec_core
  import sdec_pkg::*;
#(
  parameter int RES_BITS = sdec_pkg::RES_W
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // Modulator bitstream and sync pin
  input  wire logic                i_mod_bit,
  input  wire logic                i_modulator_sync_n,
  // Serial port handshake
  input  wire logic                i_cs_n,
  // Result towards the serial port
  output logic [RES_BITS-1:0]      o_result_output_reg,
  output logic                     o_result_ready_n,
  output logic                     o_result_valid,
  output logic                     o_mod_hold
);
  import sdec_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sync_pipe;
  logic [2:0] cs_pipe;
  logic       sync_lvl;
  logic       cs_lvl;

  // Three stages; the level moves only when the last two agree.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_pipe <= 3'h7;
      cs_pipe   <= 3'h7;
    end else begin
      sync_pipe <= {sync_pipe[1:0], i_modulator_sync_n};
      cs_pipe   <= {cs_pipe[1:0], i_cs_n};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_lvl <= 1'b1;
      cs_lvl   <= 1'b1;
    end else begin
      if (sync_pipe[1] == sync_pipe[2]) begin
        sync_lvl <= sync_pipe[2];
      end
      if (cs_pipe[1] == cs_pipe[2]) begin
        cs_lvl <= cs_pipe[2];
      end
    end
  end

  wire sync_low  = (sync_pipe[1] == sync_pipe[2]) && !sync_pipe[2];
  wire cs_fall   = cs_lvl && (cs_pipe[1] == cs_pipe[2]) && !cs_pipe[2];

  // ----------------------------------------------------------------------
  // Modulator divider and sync hold
  // ----------------------------------------------------------------------
  sdec_state_t state;
  sdec_state_t next_state;
  logic [2:0]  div_cnt;
  logic [5:0]  mod_cnt;

  // Hold while sync is low; leave the hold on the rising edge.
  always_comb begin
    next_state = state;
    case (state)
      SDEC_RUN:  if (sync_low) next_state = SDEC_HOLD;
      SDEC_HOLD: begin
        // Both late stages must read high, so a lone glitch cannot release.
        if (sync_lvl == 1'b0 && sync_pipe[1] && sync_pipe[2]) begin
          next_state = SDEC_ARM;
        end
      end
      SDEC_ARM:  next_state = SDEC_RUN;
      default:   next_state = SDEC_RUN;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= SDEC_RUN;
    end else begin
      state <= next_state;
    end
  end

  wire running  = (state != SDEC_HOLD) && !sync_low;
  wire mod_tick = running && (div_cnt == 3'(MOD_DIV - 1));
  wire dec_tick = mod_tick && (mod_cnt == 6'(DEC_RATIO - 1));

  // Counts are cleared on sync; a conversion in progress therefore restarts
  // its 64 ticks and the interrupted period comes out longer.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_cnt <= '0;
      mod_cnt <= '0;
    end else if (!running) begin
      div_cnt <= '0;
      mod_cnt <= '0;
    end else begin
      div_cnt <= mod_tick ? 3'h0 : div_cnt + 3'h1;
      if (mod_tick) begin
        mod_cnt <= mod_cnt + 6'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------------
  logic                    filt_valid;
  logic signed [ACC_W-1:0] filt_data;
  logic                    dec_q;
  logic                    shift_q;

  // The comb samples one clock after the 64th tick, so that tick's bit lies
  // inside its own period. Entering the sync hold takes one extra comb sample
  // of the frozen integrators: the next real sample is then exactly 64 ticks
  // later, and the fifth result after release sees only post-sync history.
  wire sync_shift = (state == SDEC_RUN) && sync_low && !dec_q;
  wire comb_en    = dec_q || sync_shift;
  wire conv_done  = filt_valid && !shift_q;

  // The extra sample must not look like a finished conversion.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dec_q   <= 1'b0;
      shift_q <= 1'b0;
    end else begin
      dec_q   <= dec_tick;
      shift_q <= sync_shift;
    end
  end

  // Filter state is cleared only by reset; sync only takes one extra comb sample.
  sdec_sinc5 #(
    .ACC_W (ACC_W),
    .ORDER (FILT_ORDER)
  ) u_filt (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_bit_en (mod_tick),
    .i_bit    (i_mod_bit),
    .i_dec_en (comb_en),
    .o_valid  (filt_valid),
    .o_data   (filt_data)
  );

  // Divide by 64^5 gain down to 20 bits, then clamp to avoid wrap at +FS.
  wire signed [ACC_W-1:0] scaled  = filt_data >>> SCALE_SHIFT;
  wire                    too_pos = scaled > $signed({{(ACC_W-RES_BITS){1'b0}}, POS_FULL});
  wire                    too_neg = scaled < $signed({{(ACC_W-RES_BITS){1'b1}}, NEG_FULL});
  wire [RES_BITS-1:0]     clamped = too_pos ? POS_FULL :
                                    too_neg ? NEG_FULL : scaled[RES_BITS-1:0];

  // ----------------------------------------------------------------------
  // Result register, ready strobe and validity
  // ----------------------------------------------------------------------
  logic [2:0] result_ready_n_cnt;
  logic [2:0] conv_cnt;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_result_output_reg <= RES_RESET;
    end else if (conv_done) begin
      o_result_output_reg <= clamped;
    end
  end

  // Ready goes low with the new word; a select edge or timeout ends it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_result_ready_n <= 1'b1;
      result_ready_n_cnt         <= '0;
    end else if (conv_done) begin
      o_result_ready_n <= 1'b0;
      result_ready_n_cnt         <= 3'(RESULT_READY_N_LOW_CYC);
    end else if (!o_result_ready_n && (cs_fall || result_ready_n_cnt == 3'h0)) begin
      o_result_ready_n <= 1'b1;
    end else if (result_ready_n_cnt != 3'h0) begin
      result_ready_n_cnt <= result_ready_n_cnt - 3'h1;
    end
  end

  // Validity: after reset the sixth result is the first clean one; after a
  // sync the filter history restarts, so the fifth result counts again.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      conv_cnt       <= '0;
      o_result_valid <= 1'b0;
    end else if (state == SDEC_ARM) begin
      conv_cnt       <= 3'(FIRST_VALID - SYNC_VALID - 1);
      o_result_valid <= 1'b0;
    end else if (conv_done) begin
      if (conv_cnt != 3'(FIRST_VALID - 1)) begin
        conv_cnt <= conv_cnt + 3'h1;
      end
      o_result_valid <= (conv_cnt == 3'(FIRST_VALID - 1));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mod_hold <= 1'b0;
    end else begin
      o_mod_hold <= !running;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_result_period: assert property (@(posedge i_clk) disable iff (i_rst)
    (dec_tick && running) |=> (!dec_tick)[*8])
    else $error("Conversions too close together.");
  chk_ready_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    conv_done |=> !o_result_ready_n && o_result_output_reg == $past(clamped))
    else $error("Result not loaded with ready low.");
  chk_ready_width: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_result_ready_n) |-> ##[1:6] o_result_ready_n)
    else $error("Ready low for too long.");
  chk_hold_count: assert property (@(posedge i_clk) disable iff (i_rst)
    sync_low |=> div_cnt == 3'h0 && mod_cnt == 6'h0)
    else $error("Counts not cleared during sync.");
  chk_mod_div: assert property (@(posedge i_clk) disable iff (i_rst)
    mod_tick |=> !mod_tick[*5])
    else $error("Modulator tick faster than one in six.");
  chk_no_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    conv_done && too_pos |=> o_result_output_reg == POS_FULL)
    else $error("Positive overflow wrapped.");
  chk_reg_kept: assert property (@(posedge i_clk) disable iff (i_rst)
    !conv_done |=> $stable(o_result_output_reg))
    else $error("Result register changed without conversion.");
  chk_first_valid: assert property (@(posedge i_clk) disable iff (i_rst)
    o_result_valid && !$past(o_result_valid) |-> !o_result_ready_n)
    else $error("Validity rose away from a ready pulse.");
endmodule

/* sim/sdec_reader.sv */
`timescale 1ns/1ns
// --------------------------------------------------------------------------
// Result reader on the far side of the ready line
// --------------------------------------------------------------------------
module sdec_reader
  import sdec_pkg::*;
(
  // Shared system clock
  input  wire logic             i_clk,
  // Converter outputs
  input  wire logic             i_result_ready_n,
  input  wire logic [RES_W-1:0] i_result_output_reg,
  // Behaviour select
  input  wire logic             i_answer,
  // Chip select and captured word
  output logic                  o_cs_n,
  output logic [RES_W-1:0]      o_word
);
  // Runs off the converter's own clock, so no skew between converters.
  // Select is held off 3 clocks after ready falls to respect the spacing.
  // One process owns both outputs, from their idle values onwards.
  initial begin
    o_cs_n = 1'b1;
    o_word = '0;
    forever begin
      @(negedge i_clk);
      if (i_answer && i_result_ready_n === 1'b0 && o_cs_n) begin
        repeat (3) @(negedge i_clk);
        o_cs_n = 1'b0;
        while (i_result_ready_n !== 1'b1) @(negedge i_clk);
        o_word = i_result_output_reg;
        repeat (2) @(negedge i_clk);
        o_cs_n = 1'b1;
      end
    end
  end
endmodule

/* sim/test_sinc5_decimator_with_sync.sv */
`timescale 1ns/1ns
module test_sinc5_decimator_with_sync;
  import sdec_pkg::*;
  logic             i_clk = 1'b0;
  logic             i_rst = 1'b1;
  logic             i_mod_bit = 1'b1;
  logic             i_modulator_sync_n = 1'b1;
  logic             i_cs_n;
  logic             answer = 1'b0;
  logic [RES_W-1:0] o_result_output_reg;
  logic             o_result_ready_n;
  logic             o_result_valid;
  logic             o_mod_hold;
  logic [RES_W-1:0] word;
  int               num_errors = 0;
  int               checks = 0;

  // Output rate follows the clock alone; a host picks the clock for its notches.
  always #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;

  sdec_core sdec_core_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_mod_bit(i_mod_bit),
    .i_modulator_sync_n(i_modulator_sync_n), .i_cs_n(i_cs_n),
    .o_result_output_reg(o_result_output_reg), .o_result_ready_n(o_result_ready_n),
    .o_result_valid(o_result_valid), .o_mod_hold(o_mod_hold));

  sdec_reader sdec_reader_inst (
    .i_clk(i_clk), .i_result_ready_n(o_result_ready_n),
    .i_result_output_reg(o_result_output_reg), .i_answer(answer),
    .o_cs_n(i_cs_n), .o_word(word));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Clocks until the next falling edge of ready; bounded so a dead line ends.
  task next_pulse(output int n);
    n = 0;
    while (o_result_ready_n !== 1'b1 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    while (o_result_ready_n !== 1'b0 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  task low_width(output int w);
    w = 0;
    while (o_result_ready_n === 1'b0 && w < 50) begin
      @(negedge i_clk);
      w++;
    end
  endtask

  task final_report;
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Power-up: invalid first result, fixed rate, full-scale ones saturate.
  task t_power_up;
    int n;
    int w;
    next_pulse(n);
    check(o_result_valid, 1'b0);
    low_width(w);
    check(w, RESULT_READY_N_LOW_CYC + 1);
    // The first gap adds back the measured low phase, so it runs from the fall of ready.
    for (int k = 2; k <= 6; k++) begin
      next_pulse(n);
      check(n + w, SYS_PER_CONV);
      w = 0;
      check(o_result_valid, k == 6);
    end
    check(o_result_output_reg, POS_FULL);
  endtask

  // Reader selects the part; ready returns high soon after select falls.
  task t_handshake;
    int n;
    // Change the reader's mode away from its sampling edge.
    @(posedge i_clk);
    answer = 1'b1;
    next_pulse(n);
    check(n, SYS_PER_CONV);
    n = 0;
    while (i_cs_n !== 1'b0 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    n = 0;
    while (o_result_ready_n !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    check(n <= 6, 1'b1);
    repeat (3) @(negedge i_clk);
    check(word, POS_FULL);
    answer = 1'b0;
  endtask

  // Sync low mid-conversion after an input change, then release.
  task t_sync;
    int n;
    logic [RES_W-1:0] held;
    next_pulse(n);
    i_mod_bit = 1'b0;
    repeat (100) @(negedge i_clk);
    i_modulator_sync_n = 1'b0;
    repeat (10) @(negedge i_clk);
    check(o_mod_hold, 1'b1);
    held = o_result_output_reg;
    n = 0;
    repeat (800) begin
      @(negedge i_clk);
      if (o_result_ready_n !== 1'b1)
        n++;
    end
    check(n, 0);
    check(o_result_output_reg, held);
    i_modulator_sync_n = 1'b1;
    next_pulse(n);
    check(n >= SYS_PER_CONV && n <= SYS_PER_CONV + 16, 1'b1);
    check(o_mod_hold, 1'b0);
    check(o_result_valid, 1'b0);
    for (int k = 2; k <= 5; k++) begin
      next_pulse(n);
      check(n, SYS_PER_CONV);
      check(o_result_valid, k == 5);
    end
    check(o_result_valid, 1'b1);
    check(o_result_output_reg, NEG_FULL);
    held = o_result_output_reg;
    next_pulse(n);
    check(o_result_output_reg, held);
  endtask

  // Reset in mid-run clears the outputs and restarts validity.
  task t_reset;
    int n;
    repeat (50) @(negedge i_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    check({o_result_output_reg, o_result_ready_n, o_result_valid, o_mod_hold},
          {RES_RESET, 3'b100});
    i_rst = 1'b0;
    next_pulse(n);
    check(o_result_valid, 1'b0);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    t_power_up();
    t_handshake();
    t_sync();
    t_reset();
    final_report();
  end

  // The run needs about 6750 clocks; three times that means a hang.
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    final_report();
  end
endmodule
